// *** inc/cpu_regs_defines.svh ***
// Constants for the core register set.
`ifndef CPU_REGS_DEFINES_SVH
`define CPU_REGS_DEFINES_SVH

`define FLAG_CARRY_BIT    3'd0
`define FLAG_ZERO_BIT     3'd1
`define FLAG_NEG_BIT      3'd2
`define FLAG_PRIO_LO_BIT  3'd3
`define FLAG_HALF_BIT     3'd4
`define FLAG_PRIO_HI_BIT  3'd5
`define FLAG_RESET        8'hE8
`define FLAG_FIXED_MASK   8'hC0
`define STACK_PAGE        8'h01
`define STACK_LOW_RESET   8'hFF
`define IRQ_FRAME_BYTES   3'd5
`define CALL_FRAME_BYTES  3'd2
`define IP_RESET          16'h0000

`endif

// *** inc/cpu_regs_pkg.sv ***
// Types for the core register set.
`default_nettype none
package cpu_regs_pkg;
  // Register-file operations driven by the instruction sequencer.
  typedef enum logic [3:0] {
    OP_NONE      = 4'h0,
    OP_WRITE     = 4'h1,
    OP_ALU       = 4'h2,
    OP_SET_CARRY = 4'h3,
    OP_CLR_CARRY = 4'h4,
    OP_SET_PRIO  = 4'h5,
    OP_PUSH      = 4'h6,
    OP_POP       = 4'h7,
    OP_CALL      = 4'h8,
    OP_RET       = 4'h9,
    OP_IRQ       = 4'hA,
    OP_IRQ_RETURN_INSTR      = 4'hB,
    OP_RSP       = 4'hC
  } reg_op_t;
  typedef enum logic [2:0] {
    SEL_WORK  = 3'd0,
    SEL_OFS1  = 3'd1,
    SEL_OFS2  = 3'd2,
    SEL_IPL   = 3'd3,
    SEL_IPH   = 3'd4,
    SEL_FLAG  = 3'd5,
    SEL_SPL   = 3'd6
  } reg_sel_t;
  typedef enum logic [6:0] {
    ST_IDLE = 7'b0000001,
    ST_SAVE = 7'b0000010,
    ST_REST = 7'b0000100,
    ST_CALL = 7'b0001000,
    ST_RET  = 7'b0010000,
    ST_P1   = 7'b0100000,
    ST_P2   = 7'b1000000
  } seq_state_t;
  typedef struct packed {
    logic [7:0]  work_reg;
    logic [7:0]  ofs1_reg;
    logic [7:0]  ofs2_reg;
    logic [15:0] ip_reg;
    logic [7:0]  flag_reg;
    logic [7:0]  spl_reg;
    seq_state_t  state_reg;
    logic [2:0]  cnt_reg;
    logic [7:0]  wdata_reg;
    logic        we_reg;
    logic [15:0] addr_reg;
    logic        re_reg;
  } core_state_t;
endpackage : cpu_regs_pkg
`default_nettype wire

// *** hdl/cpu_core_register_set.sv ***
// Architectural register set of the 8-bit core with stack sequencing.
`include "cpu_regs_defines.svh"
`default_nettype none
module cpu_core_register_set
  import cpu_regs_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire reg_op_t     op,
  input  wire reg_sel_t    sel,
  input  wire logic        prefix_second,
  input  wire logic [7:0]  wr_data,
  input  wire logic [15:0] ip_wr_data,
  input  wire logic        ip_wr,
  input  wire logic [7:0]  alu_result,
  input  wire logic        alu_carry,
  input  wire logic        alu_half,
  input  wire logic        alu_is_add,
  input  wire logic        alu_carry_upd,
  input  wire logic [1:0]  source_priority_regs,
  input  wire logic [7:0]  stack_rd_data,
  output logic [7:0]       rd_data,
  output logic             busy,
  output logic [15:0]      stack_addr,
  output logic [7:0]       stack_wr_data,
  output logic             stack_we,
  output logic             stack_re,
  output logic [7:0]       working_register,
  output logic [7:0]       first_offset_register,
  output logic [7:0]       second_offset_register,
  output logic [15:0]      instruction_pointer,
  output logic [7:0]       flag_word,
  output logic [15:0]      stack_pointer,
  output logic [1:0]       priority_level
);

  // ****************************************
  // Reset release
  // ****************************************
  logic [1:0] rst_sync_reg;
  logic       rst_n;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      rst_sync_reg <= 2'b00;
    else
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end
  assign rst_n = rst_sync_reg[1];

  // ****************************************
  // State
  // ****************************************
  core_state_t s_reg;
  core_state_t s_next;
  logic [15:0] sp_full;
  logic [7:0]  sp_dec;
  logic [7:0]  sp_inc;
  logic [7:0]  save_byte;
  logic        restore_is_call;

  assign sp_full = {`STACK_PAGE, s_reg.spl_reg};
  assign sp_dec  = s_reg.spl_reg - 8'h01;
  assign sp_inc  = s_reg.spl_reg + 8'h01;

  // Interrupt frame order; the second offset register never appears here.
  always_comb
  begin
    case (s_reg.cnt_reg)
      3'd0:    save_byte = s_reg.ip_reg[7:0];
      3'd1:    save_byte = s_reg.ip_reg[15:8];
      3'd2:    save_byte = s_reg.ofs1_reg;
      3'd3:    save_byte = s_reg.work_reg;
      default: save_byte = s_reg.flag_reg;
    endcase
  end

  always_comb
  begin
    s_next          = s_reg;
    s_next.we_reg   = 1'b0;
    s_next.re_reg   = 1'b0;
    case (s_reg.state_reg)
      ST_IDLE:
      begin
        if (ip_wr)
          s_next.ip_reg = ip_wr_data;
        case (op)
          OP_WRITE:
          begin
            case (sel)
              SEL_WORK: s_next.work_reg = wr_data;
              SEL_OFS1:
              begin
                if (prefix_second)
                  s_next.ofs2_reg = wr_data;
                else
                  s_next.ofs1_reg = wr_data;
              end
              SEL_OFS2: s_next.ofs2_reg = wr_data;
              SEL_IPL:  s_next.ip_reg[7:0] = wr_data;
              SEL_IPH:  s_next.ip_reg[15:8] = wr_data;
              SEL_FLAG: s_next.flag_reg = wr_data | `FLAG_FIXED_MASK;
              SEL_SPL:  s_next.spl_reg = wr_data;
              default:  s_next.work_reg = s_reg.work_reg;
            endcase
          end
          OP_ALU:
          begin
            s_next.flag_reg[`FLAG_NEG_BIT]  = alu_result[7];
            s_next.flag_reg[`FLAG_ZERO_BIT] = (alu_result == 8'h00);
            if (alu_is_add)
              s_next.flag_reg[`FLAG_HALF_BIT] = alu_half;
            if (alu_carry_upd)
              s_next.flag_reg[`FLAG_CARRY_BIT] = alu_carry;
          end
          OP_SET_CARRY: s_next.flag_reg[`FLAG_CARRY_BIT] = 1'b1;
          OP_CLR_CARRY: s_next.flag_reg[`FLAG_CARRY_BIT] = 1'b0;
          OP_SET_PRIO:
          begin
            s_next.flag_reg[`FLAG_PRIO_HI_BIT] = wr_data[1];
            s_next.flag_reg[`FLAG_PRIO_LO_BIT] = wr_data[0];
          end
          OP_RSP: s_next.spl_reg = `STACK_LOW_RESET;
          OP_PUSH:
          begin
            s_next.we_reg    = 1'b1;
            s_next.addr_reg  = sp_full;
            s_next.wdata_reg = wr_data;
            s_next.spl_reg   = sp_dec;
          end
          OP_POP:
          begin
            s_next.spl_reg   = sp_inc;
            s_next.addr_reg  = {`STACK_PAGE, sp_inc};
            s_next.re_reg    = 1'b1;
            s_next.state_reg = ST_P1;
          end
          OP_CALL:
          begin
            s_next.cnt_reg   = 3'd0;
            s_next.state_reg = ST_CALL;
          end
          OP_RET:
          begin
            s_next.cnt_reg   = 3'd0;
            s_next.state_reg = ST_RET;
          end
          OP_IRQ:
          begin
            s_next.cnt_reg   = 3'd0;
            s_next.state_reg = ST_SAVE;
          end
          OP_IRQ_RETURN_INSTR:
          begin
            s_next.cnt_reg   = 3'd0;
            s_next.state_reg = ST_REST;
          end
          default: s_next.state_reg = ST_IDLE;
        endcase
      end
      ST_CALL:
      begin
        s_next.we_reg    = 1'b1;
        s_next.addr_reg  = sp_full;
        s_next.wdata_reg = (s_reg.cnt_reg == 3'd0) ? s_reg.ip_reg[7:0] : s_reg.ip_reg[15:8];
        s_next.spl_reg   = sp_dec;
        s_next.cnt_reg   = s_reg.cnt_reg + 3'd1;
        if (s_reg.cnt_reg + 3'd1 == `CALL_FRAME_BYTES)
        begin
          s_next.ip_reg    = ip_wr_data;
          s_next.state_reg = ST_IDLE;
        end
      end
      ST_SAVE:
      begin
        s_next.we_reg    = 1'b1;
        s_next.addr_reg  = sp_full;
        s_next.wdata_reg = save_byte;
        s_next.spl_reg   = sp_dec;
        s_next.cnt_reg   = s_reg.cnt_reg + 3'd1;
        if (s_reg.cnt_reg + 3'd1 == `IRQ_FRAME_BYTES)
        begin
          s_next.flag_reg[`FLAG_PRIO_HI_BIT] = source_priority_regs[1];
          s_next.flag_reg[`FLAG_PRIO_LO_BIT] = source_priority_regs[0];
          s_next.ip_reg    = ip_wr_data;
          s_next.state_reg = ST_IDLE;
        end
      end
      ST_RET, ST_REST:
      begin
        s_next.spl_reg   = sp_inc;
        s_next.addr_reg  = {`STACK_PAGE, sp_inc};
        s_next.re_reg    = 1'b1;
        s_next.state_reg = ST_P2;
      end
      ST_P1:
      begin
        // Pop completion: byte lands in the selected work, offset or flag register; other selections drop it.
        case (sel)
          SEL_WORK: s_next.work_reg = stack_rd_data;
          SEL_OFS1:
          begin
            if (prefix_second)
              s_next.ofs2_reg = stack_rd_data;
            else
              s_next.ofs1_reg = stack_rd_data;
          end
          SEL_OFS2: s_next.ofs2_reg = stack_rd_data;
          SEL_FLAG: s_next.flag_reg = stack_rd_data | `FLAG_FIXED_MASK;
          default:  s_next.work_reg = s_reg.work_reg;
        endcase
        s_next.state_reg = ST_IDLE;
      end
      ST_P2:
      begin
        // Restoration runs in reverse of the save order.
        s_next.cnt_reg = s_reg.cnt_reg + 3'd1;
        if (s_reg.addr_reg[15:8] == `STACK_PAGE && s_reg.we_reg == 1'b0)
        begin
          if (s_next.cnt_reg == 3'd0)
            s_next.cnt_reg = 3'd0;
        end
        s_next.state_reg = ST_IDLE;
        if (s_reg.cnt_reg[2] == 1'b0 && op != OP_RET)
          s_next.state_reg = ST_IDLE;
      end
      default: s_next.state_reg = ST_IDLE;
    endcase
    if (s_reg.state_reg == ST_P2)
    begin
      s_next.state_reg = ST_IDLE;
      if (!restore_is_call)
      begin
        case (s_reg.cnt_reg)
          3'd0: s_next.flag_reg = stack_rd_data | `FLAG_FIXED_MASK;
          3'd1: s_next.work_reg = stack_rd_data;
          3'd2: s_next.ofs1_reg = stack_rd_data;
          3'd3: s_next.ip_reg[15:8] = stack_rd_data;
          default: s_next.ip_reg[7:0] = stack_rd_data;
        endcase
        if (s_reg.cnt_reg != `IRQ_FRAME_BYTES - 3'd1)
          s_next.state_reg = ST_REST;
      end
      else
      begin
        if (s_reg.cnt_reg == 3'd0)
          s_next.ip_reg[15:8] = stack_rd_data;
        else
          s_next.ip_reg[7:0] = stack_rd_data;
        if (s_reg.cnt_reg != `CALL_FRAME_BYTES - 3'd1)
          s_next.state_reg = ST_RET;
      end
    end
  end

  // Remembers whether the running restore is a call return.
  logic restore_is_call_reg;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      restore_is_call_reg <= 1'b0;
    else if (s_reg.state_reg == ST_IDLE && op == OP_RET)
      restore_is_call_reg <= 1'b1;
    else if (s_reg.state_reg == ST_IDLE && op == OP_IRQ_RETURN_INSTR)
      restore_is_call_reg <= 1'b0;
  end
  assign restore_is_call = restore_is_call_reg;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_reg           <= '0;
      s_reg.state_reg <= ST_IDLE;
      s_reg.ip_reg    <= `IP_RESET;
      s_reg.flag_reg  <= `FLAG_RESET;
      s_reg.spl_reg   <= `STACK_LOW_RESET;
    end
    else
      s_reg <= s_next;
  end

  // ****************************************
  // Outputs
  // ****************************************
  always_comb
  begin
    case (sel)
      SEL_WORK: rd_data = s_reg.work_reg;
      SEL_OFS1: rd_data = prefix_second ? s_reg.ofs2_reg : s_reg.ofs1_reg;
      SEL_OFS2: rd_data = s_reg.ofs2_reg;
      SEL_IPL:  rd_data = s_reg.ip_reg[7:0];
      SEL_IPH:  rd_data = s_reg.ip_reg[15:8];
      SEL_FLAG: rd_data = s_reg.flag_reg;
      SEL_SPL:  rd_data = s_reg.spl_reg;
      default:  rd_data = 8'h00;
    endcase
  end

  // Level from the upper and lower priority bits.
  always_comb
  begin
    case ({s_reg.flag_reg[`FLAG_PRIO_HI_BIT], s_reg.flag_reg[`FLAG_PRIO_LO_BIT]})
      2'b10:   priority_level = 2'd0;
      2'b01:   priority_level = 2'd1;
      2'b00:   priority_level = 2'd2;
      default: priority_level = 2'd3;
    endcase
  end

  assign busy                   = (s_reg.state_reg != ST_IDLE);
  assign stack_addr             = s_reg.addr_reg;
  assign stack_wr_data          = s_reg.wdata_reg;
  assign stack_we               = s_reg.we_reg;
  assign stack_re               = s_reg.re_reg;
  assign working_register       = s_reg.work_reg;
  assign first_offset_register  = s_reg.ofs1_reg;
  assign second_offset_register = s_reg.ofs2_reg;
  assign instruction_pointer    = s_reg.ip_reg;
  assign flag_word              = s_reg.flag_reg;
  assign stack_pointer          = sp_full;

endmodule : cpu_core_register_set
`default_nettype wire

// *** tb/cpu_regs_checker.sv ***
// Port assertions for the core register set.
`default_nettype none
module cpu_regs_checker
  import cpu_regs_pkg::*;
(
  input wire logic        clk,
  input wire logic        arst_n,
  input wire reg_op_t     op,
  input wire logic        busy,
  input wire logic [7:0]  alu_result,
  input wire logic        alu_carry,
  input wire logic        alu_half,
  input wire logic        alu_is_add,
  input wire logic        alu_carry_upd,
  input wire logic [1:0]  source_priority_regs,
  input wire logic [15:0] stack_addr,
  input wire logic        stack_we,
  input wire logic [7:0]  flag_word,
  input wire logic [7:0]  second_offset_register,
  input wire logic [15:0] stack_pointer,
  input wire logic [1:0]  priority_level
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // Helpers and sequences
  // ****************************************
  logic [7:0] sp_low;
  logic [1:0] level_exp;
  assign sp_low    = stack_pointer[7:0];
  assign level_exp = {~(flag_word[5] ^ flag_word[3]), flag_word[3]};
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence irq_start;
    op == OP_IRQ && !busy;
  endsequence
  sequence irq_frame;
    stack_we && stack_addr == $past(stack_pointer) ##1 stack_we [*4] ##1 !stack_we;
  endsequence
  sequence call_start;
    op == OP_CALL && !busy;
  endsequence
  // ****************************************
  // Assertions
  // ****************************************
  sp_page_a: assert property (stack_pointer[15:8] == 8'h01)
    else $error("stack page moved");
  level_map_a: assert property (priority_level == level_exp)
    else $error("priority level decode wrong");
  push_step_a: assert property (op == OP_PUSH && !busy |=> stack_we
    && stack_addr == $past(stack_pointer) && sp_low == $past(sp_low) - 8'h01)
    else $error("push step wrong");
  irq_frame_a: assert property (irq_start |-> ##2 irq_frame)
    else $error("interrupt frame writes wrong");
  irq_space_a: assert property (irq_start |-> ##6 sp_low == $past(sp_low, 6) - 8'h05)
    else $error("interrupt stack use wrong");
  irq_level_a: assert property (irq_start |-> ##6
    {flag_word[5], flag_word[3]} == source_priority_regs)
    else $error("interrupt priority not loaded");
  ofs2_keep_a: assert property (irq_start |=> $stable(second_offset_register) [*5])
    else $error("second offset touched by interrupt");
  call_space_a: assert property (call_start |-> ##2 stack_we [*2]
    ##1 (!stack_we && sp_low == $past(sp_low, 4) - 8'h02))
    else $error("call stack use wrong");
  flag_result_a: assert property (op == OP_ALU && !busy |=>
    flag_word[2:1] == {$past(alu_result) >= 8'h80, $past(alu_result) == 8'h00})
    else $error("sign or zero flag wrong");
  half_carry_a: assert property (op == OP_ALU && alu_is_add && !busy |=>
    flag_word[4] == $past(alu_half))
    else $error("half carry wrong");
  carry_alu_a: assert property (op == OP_ALU && alu_carry_upd && !busy |=>
    flag_word[0] == $past(alu_carry))
    else $error("carry from alu wrong");
  carry_force_a: assert property ((op == OP_SET_CARRY || op == OP_CLR_CARRY) && !busy
    |=> flag_word[0] == ($past(op) == OP_SET_CARRY))
    else $error("carry force wrong");
  stack_reinit_a: assert property (op == OP_RSP && !busy |=> stack_pointer == 16'h01FF)
    else $error("stack reinit wrong");
endmodule : cpu_regs_checker

bind cpu_core_register_set cpu_regs_checker i_chk (.clk, .arst_n, .op, .busy, .alu_result,
  .alu_carry, .alu_half, .alu_is_add, .alu_carry_upd, .source_priority_regs, .stack_addr,
  .stack_we, .flag_word, .second_offset_register, .stack_pointer, .priority_level);
`default_nettype wire

// *** tb/stack_mem_model.sv ***
// Behavioural stack memory facing the register set.
`default_nettype none
module stack_mem_model
(
  input wire logic        clk,
  input wire logic [15:0] stack_addr,
  input wire logic [7:0]  stack_wr_data,
  input wire logic        stack_we,
  input wire logic        stack_re,
  output logic [7:0]      stack_rd_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [256];
  logic [7:0] rd_q = 8'h00;
  // Read data answers while the strobe stands; otherwise the inverse shows, so a late
  // sample shows up.
  assign stack_rd_data = stack_re ? mem[stack_addr[7:0]] : ~rd_q;
  always @(posedge clk)
  begin
    if (stack_we)
      mem[stack_addr[7:0]] <= stack_wr_data;
    rd_q <= stack_rd_data;
  end
endmodule : stack_mem_model
`default_nettype wire

// *** tb/cpu_core_register_set_bench.sv ***
// Self-checking bench for the core register set.
`default_nettype none
module cpu_core_register_set_bench
  import cpu_regs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, busy, stack_we, stack_re;
  logic        arst_n = 1'b0;
  logic        prefix_second = 1'b0;
  logic        ip_wr = 1'b0;
  logic        alu_carry = 1'b0;
  logic        alu_half = 1'b0;
  logic        alu_is_add = 1'b1;
  logic        alu_carry_upd = 1'b1;
  reg_op_t     op = OP_NONE;
  reg_sel_t    sel = SEL_WORK;
  logic [7:0]  wr_data = 8'h00;
  logic [7:0]  alu_result = 8'h00;
  logic [15:0] ip_wr_data = 16'h0000;
  logic [1:0]  source_priority_regs = 2'b01;
  logic [7:0]  rd_data, stack_wr_data, stack_rd_data, f0, s0;
  logic [7:0]  working_register, first_offset_register, second_offset_register, flag_word;
  logic [15:0] stack_addr, instruction_pointer, stack_pointer;
  logic [1:0]  priority_level;
  logic [1:0]  lvl [4] = '{2'd2, 2'd1, 2'd0, 2'd3};
  int          n_errors = 0;
  int          comparisons = 0;

  cpu_core_register_set i_dut (.clk, .arst_n, .op, .sel, .prefix_second, .wr_data, .ip_wr_data,
    .ip_wr, .alu_result, .alu_carry, .alu_half, .alu_is_add, .alu_carry_upd,
    .source_priority_regs, .stack_rd_data, .rd_data, .busy, .stack_addr, .stack_wr_data,
    .stack_we, .stack_re, .working_register, .first_offset_register, .second_offset_register,
    .instruction_pointer, .flag_word, .stack_pointer, .priority_level);
  stack_mem_model i_mem (.clk, .stack_addr, .stack_wr_data, .stack_we, .stack_re, .stack_rd_data);

  // ****************************************
  // Access tasks
  // ****************************************
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // Waits out the busy span, then two more cycles so popped data has landed.
  task automatic do_op(input reg_op_t o, input reg_sel_t s, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    op <= o;
    sel <= s;
    wr_data <= d;
    @(posedge clk);
    op <= OP_NONE;
    #1;
    while (busy !== 1'b0 && n < 20)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    check("busy", 1'b0, busy);
    repeat (2) @(posedge clk);
    #1;
  endtask : do_op

  task automatic set_ip(input logic [15:0] v, input logic [15:0] target);
    @(posedge clk);
    ip_wr_data <= v;
    ip_wr <= 1'b1;
    @(posedge clk);
    ip_wr <= 1'b0;
    ip_wr_data <= target;
  endtask : set_ip

  task automatic alu(input logic [7:0] r, input logic c, h, u, ce);
    @(posedge clk);
    alu_result <= r;
    alu_carry <= c;
    alu_half <= h;
    alu_is_add <= u;
    alu_carry_upd <= u;
    do_op(OP_ALU, SEL_WORK, 8'h00);
    check("nzc", {r[7], r == 8'h00, ce}, flag_word[2:0]);
    if (u)
      check("half", h, flag_word[4]);
  endtask : alu

  task automatic give_verdict();
    if (n_errors == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : give_verdict

  // ****************************************
  // Clock, watchdog and tests
  // ****************************************
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial
  begin
    repeat (5000) @(posedge clk);
    n_errors++;
    give_verdict();
  end

  initial
  begin
    repeat (12) @(posedge clk);
    check("sp", 16'h01FF, stack_pointer);
    check("flags", 8'hE8, flag_word);
    check("level", 2'd3, priority_level);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
    do_op(OP_WRITE, SEL_WORK, 8'hA5);
    check("work", 8'hA5, working_register);
    check("rd", 8'hA5, rd_data);
    do_op(OP_WRITE, SEL_OFS1, 8'h3C);
    prefix_second <= 1'b1;
    do_op(OP_WRITE, SEL_OFS1, 8'h77);
    check("ofs2", 8'h77, second_offset_register);
    check("ofs1", 8'h3C, first_offset_register);
    prefix_second <= 1'b0;
    do_op(OP_WRITE, SEL_SPL, 8'h00);
    check("sp", 16'h0100, stack_pointer);
    check("rd", 8'h00, rd_data);
    do_op(OP_PUSH, SEL_SPL, 8'h5A);
    check("mem", 8'h5A, i_mem.mem[0]);
    check("sp", 16'h01FF, stack_pointer);
    do_op(OP_POP, SEL_OFS1, 8'h00);
    check("ofs1", 8'h5A, first_offset_register);
    check("sp", 16'h0100, stack_pointer);
    alu(8'h00, 1'b0, 1'b1, 1'b1, 1'b0);
    alu(8'h80, 1'b1, 1'b0, 1'b1, 1'b1);
    alu(8'h01, 1'b0, 1'b0, 1'b0, 1'b1);
    do_op(OP_CLR_CARRY, SEL_WORK, 8'h00);
    check("carry", 1'b0, flag_word[0]);
    do_op(OP_SET_CARRY, SEL_WORK, 8'h00);
    check("carry", 1'b1, flag_word[0]);
    for (int i = 0; i < 4; i++)
    begin
      do_op(OP_SET_PRIO, SEL_WORK, {6'h00, i[1:0]});
      check("prio", i[1:0], {flag_word[5], flag_word[3]});
      check("level", lvl[i], priority_level);
    end
    // The frame straddles the wrap from the bottom of the page to its top.
    set_ip(16'h1234, 16'h0F00);
    f0 = flag_word;
    s0 = stack_pointer[7:0];
    do_op(OP_IRQ, SEL_WORK, 8'h00);
    check("ip_lo", 8'h34, i_mem.mem[s0]);
    check("ip_hi", 8'h12, i_mem.mem[s0 - 8'd1]);
    check("ofs1", 8'h5A, i_mem.mem[s0 - 8'd2]);
    check("work", 8'hA5, i_mem.mem[s0 - 8'd3]);
    check("flags", f0, i_mem.mem[s0 - 8'd4]);
    check("sp", {8'h01, s0 - 8'd5}, stack_pointer);
    check("ip", 16'h0F00, instruction_pointer);
    check("prio", 2'b01, {flag_word[5], flag_word[3]});
    check("ofs2", 8'h77, second_offset_register);
    do_op(OP_WRITE, SEL_WORK, 8'h00);
    do_op(OP_IRQ_RETURN_INSTR, SEL_WORK, 8'h00);
    check("work", 8'hA5, working_register);
    check("flags", f0, flag_word);
    check("ip", 16'h1234, instruction_pointer);
    check("sp", {8'h01, s0}, stack_pointer);
    set_ip(16'h4321, 16'h0BEE);
    s0 = stack_pointer[7:0];
    do_op(OP_CALL, SEL_WORK, 8'h00);
    check("ip_lo", 8'h21, i_mem.mem[s0]);
    check("ip_hi", 8'h43, i_mem.mem[s0 - 8'd1]);
    check("sp", {8'h01, s0 - 8'd2}, stack_pointer);
    check("ip", 16'h0BEE, instruction_pointer);
    do_op(OP_RET, SEL_WORK, 8'h00);
    check("ip", 16'h4321, instruction_pointer);
    do_op(OP_RSP, SEL_WORK, 8'h00);
    check("sp", 16'h01FF, stack_pointer);
    give_verdict();
  end
endmodule : cpu_core_register_set_bench
`default_nettype wire
